/* include/cbram_pkg.sv */
// package: constants and types of the configurable block ram with emulated dual clock ports
package cbram_pkg;

  localparam int DATA_W    = 20;
  localparam int ADDR_W    = 10;
  localparam int STAMP_W   = 8;
  localparam int COLL_W    = 16;
  localparam int PADDR_W   = 12;
  localparam int LAT_A_MIN = 4;   // port a read latency floor, in port a clock cycles
  localparam int LAT_B     = 2;   // port b read latency, in port b clock cycles

  localparam logic [PADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_GEOM = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_STAT = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_COLL = 12'h00C;

  localparam logic [1:0] OP_SDP     = 2'h0;
  localparam logic [1:0] OP_TDP     = 2'h1;
  localparam logic [1:0] OP_SQP     = 2'h2;
  localparam logic [1:0] OP_SP      = 2'h3;
  localparam logic [1:0] DEPTH_512  = 2'h0;
  localparam logic [1:0] DEPTH_1024 = 2'h1;
  localparam logic [1:0] DEPTH_2048 = 2'h2;

  // width ratios are held as log2
  localparam logic [2:0] RATIO_1        = 3'h0;
  localparam logic [2:0] RATIO_MAX_BE   = 3'h2;
  localparam logic [2:0] RATIO_EMUL_MIN = 3'h3;
  localparam logic [2:0] RATIO_MAX_NOBE = 3'h5;

  typedef struct packed {
    logic run;
    logic freeze;
    logic safe;
  } cbram_ctrl_t;
  localparam cbram_ctrl_t CTRL_RST = 3'h0;

  typedef struct packed {
    logic       mem_small;
    logic [1:0] op;
    logic [1:0] depth;
    logic       parity;
    logic [2:0] ratio;
    logic       byte_en;
    logic       emul;
    logic       clk_indep;
  } cbram_geom_t;
  // true dual port, 1024 x 20, emulated dual clock
  localparam cbram_geom_t GEOM_RST = 12'h2C3;

  typedef struct packed {
    logic legal;
    logic ratio_emul;
    logic rdaddr_ext;
    logic active;
    logic req_full;
    logic resp_full;
  } cbram_stat_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cbram_req_t;

  typedef struct packed {
    cbram_req_t         req;
    logic [STAMP_W-1:0] stamp;
  } cbram_areq_t;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [STAMP_W-1:0] stamp;
  } cbram_resp_t;

endpackage

/* logic/cbram_dual_clock.sv */
// design: block ram core with apb configuration and emulated dual clock true dual port
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////
// Operation
// - 512 deep x32/x40 only simple dual port
// - 1024 deep x16/x20 simple or true dual
// - 2048 deep x8/x10 sdp, tdp, quad, single port
// - mixed widths only in simple dual port
// - ratio up to 32, 4 with byte enables
// - ratios 8-32 emulated, init by wider port
// - small memory never mixes port widths
// - same address dual write behaviour defined
// - default dual write corrupts the word
// - safe option: b first, a remains stored
// - optional freeze gating for reconfiguration
// - emulation needs two rw ports, own clocks
// - two fifos around one ram
// - valid flag marks meaningful read data
// - port a latency at least four cycles
// - port b latency exactly two cycles
// - output registers always used
// - small memory: din, dout, waddr registers
// - small memory read address from logic
// - read clock and write clock register split
module cbram_dual_clock #(
  parameter int FIFO_DEPTH = 4
) (
  input  logic                          pclk,
  input  logic                          presetn,
  input  logic                          psel,
  input  logic                          penable,
  input  logic                          pwrite,
  input  logic [cbram_pkg::PADDR_W-1:0] paddr,
  input  logic [31:0]                   pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  logic                          clk_a,
  input  logic                          clken_a,
  input  cbram_pkg::cbram_req_t         req_a,
  output logic                          ready_a,
  output logic [cbram_pkg::DATA_W-1:0]  q_a,
  output logic                          valid_a,
  input  logic                          clk_b,
  input  logic                          clken_b,
  input  cbram_pkg::cbram_req_t         req_b,
  output logic [cbram_pkg::DATA_W-1:0]  q_b,
  output logic                          valid_b
);
  import cbram_pkg::*;

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = PTR_W + 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

  //////////////////////////////////////////////////////////////////////////////////////////
  // port clock pins: synchronised, rising edge turned into a one-cycle tick

  logic [1:0] pin;
  logic [1:0] tick;
  assign pin = {clk_b, clk_a};

  genvar g;
  for (g = 0; g < 2; g++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1  <= 1'b0;
        s2  <= 1'b0;
        s3  <= 1'b0;
        lvl <= 1'b0;
      end else begin
        s1 <= pin[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          lvl <= s3;
        end
      end
    end
    assign tick[g] = s2 & s3 & ~lvl;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // configuration checking

  function automatic logic geom_ok(input cbram_geom_t gm);
    logic ok;
    ok = 1'b1;
    if (gm.mem_small) begin
      if (gm.ratio != RATIO_1 || gm.emul) begin
        ok = 1'b0;
      end
    end else if (gm.depth == DEPTH_512) begin
      if (gm.op != OP_SDP) begin
        ok = 1'b0;
      end
    end else if (gm.depth == DEPTH_1024) begin
      if (gm.op != OP_SDP && gm.op != OP_TDP) begin
        ok = 1'b0;
      end
    end else if (gm.depth == DEPTH_2048) begin
      if (gm.op == OP_SP) begin
        ok = 1'b1;
      end
    end else begin
      ok = 1'b0;
    end
    if (gm.ratio != RATIO_1 && gm.op != OP_SDP) begin
      ok = 1'b0;
    end
    if (gm.ratio > (gm.byte_en ? RATIO_MAX_BE : RATIO_MAX_NOBE)) begin
      ok = 1'b0;
    end
    if (gm.emul && !(gm.op == OP_TDP && gm.clk_indep)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  cbram_ctrl_t ctrl;
  cbram_ctrl_t next_ctrl;
  cbram_geom_t geom;
  cbram_geom_t next_geom;
  cbram_stat_t stat;
  logic [31:0] next_prdata;
  logic        legal;
  logic        active;
  logic        frozen;

  assign legal  = geom_ok(geom);
  assign active = ctrl.run & legal & geom.emul;
  assign frozen = ctrl.freeze;

  //////////////////////////////////////////////////////////////////////////////////////////
  // request and response fifos, port pipelines

  cbram_areq_t        req_mem [FIFO_DEPTH];
  cbram_resp_t        resp_mem[FIFO_DEPTH];
  logic [DATA_W-1:0]  mem     [2**ADDR_W];

  logic [PTR_W-1:0]   req_wr, req_rd, resp_wr, resp_rd;
  logic [PTR_W-1:0]   next_req_wr, next_req_rd, next_resp_wr, next_resp_rd;
  logic [CNT_W-1:0]   req_cnt, resp_cnt, next_req_cnt, next_resp_cnt;
  logic [STAMP_W-1:0] a_cnt, next_a_cnt;
  logic [STAMP_W-1:0] a_age;
  cbram_req_t         b_s1, next_b_s1;
  logic               b_s1_v, next_b_s1_v;
  logic [DATA_W-1:0]  b_rd, next_b_rd;
  logic               b_rd_v, next_b_rd_v;
  logic [DATA_W-1:0]  next_q_a, next_q_b;
  logic               next_valid_a, next_valid_b;
  logic [COLL_W-1:0]  coll_cnt, next_coll_cnt;
  cbram_areq_t        a_head;
  cbram_resp_t        r_head;
  logic               a_tick, b_tick, a_adv, b_adv;
  logic               req_full, resp_full, a_push, a_srv, a_pop;
  logic               wa, wb, coll;

  assign a_tick    = tick[0];
  assign b_tick    = tick[1];
  assign a_adv     = a_tick & clken_a & ~frozen;
  assign b_adv     = b_tick & clken_b & ~frozen;
  assign req_full  = (req_cnt == CNT_FULL);
  assign resp_full = (resp_cnt == CNT_FULL);
  assign a_head    = req_mem[req_rd];
  assign r_head    = resp_mem[resp_rd];
  assign a_age     = a_cnt - r_head.stamp;

  // fifo full stalls port a; the user must hold its request while ready_a is low
  assign ready_a = active & ~req_full & ~frozen;
  assign a_push  = a_adv & active & ~req_full & (req_a.we | req_a.re);
  // port a is served on port b ticks, so the slow side never outruns the ram
  assign a_srv   = b_tick & ~frozen & (req_cnt != '0) & ~resp_full;
  assign a_pop   = a_adv & (resp_cnt != '0) & (a_age >= STAMP_W'(LAT_A_MIN));

  assign wb   = b_adv & b_s1_v & b_s1.we;
  assign wa   = a_srv & a_head.req.we;
  assign coll = wa & wb & (a_head.req.addr == b_s1.addr);

  always_comb begin
    next_req_wr   = req_wr;
    next_req_rd   = req_rd;
    next_resp_wr  = resp_wr;
    next_resp_rd  = resp_rd;
    next_req_cnt  = req_cnt;
    next_resp_cnt = resp_cnt;
    next_a_cnt    = a_tick ? a_cnt + 1'b1 : a_cnt;
    next_b_s1     = b_s1;
    next_b_s1_v   = b_s1_v;
    next_b_rd     = b_rd;
    next_b_rd_v   = b_rd_v;
    next_q_a      = q_a;
    next_q_b      = q_b;
    next_valid_a  = valid_a;
    next_valid_b  = valid_b;
    next_coll_cnt = coll ? coll_cnt + 1'b1 : coll_cnt;
    if (a_push) begin
      next_req_wr = (req_wr == PTR_LAST) ? '0 : req_wr + 1'b1;
    end
    if (a_srv) begin
      next_req_rd = (req_rd == PTR_LAST) ? '0 : req_rd + 1'b1;
    end
    next_req_cnt = req_cnt + CNT_W'(a_push) - CNT_W'(a_srv);
    if (a_srv && a_head.req.re) begin
      next_resp_wr = (resp_wr == PTR_LAST) ? '0 : resp_wr + 1'b1;
    end
    if (a_pop) begin
      next_resp_rd = (resp_rd == PTR_LAST) ? '0 : resp_rd + 1'b1;
    end
    next_resp_cnt = resp_cnt + CNT_W'(a_srv & a_head.req.re) - CNT_W'(a_pop);
    // port a valid register moves on every enabled port a edge; q_a loads only when a response pops
    if (a_adv) begin
      next_valid_a = a_pop;
      if (a_pop) begin
        next_q_a = r_head.data;
      end
    end
    // port b: input register, ram read register, output register
    if (b_adv) begin
      next_b_s1   = req_b;
      next_b_s1_v = req_b.we | req_b.re;
      next_b_rd   = mem[b_s1.addr];
      next_b_rd_v = b_s1_v & b_s1.re;
      next_q_b    = b_rd;
      next_valid_b = b_rd_v;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_wr   <= '0;
      req_rd   <= '0;
      resp_wr  <= '0;
      resp_rd  <= '0;
      req_cnt  <= '0;
      resp_cnt <= '0;
      a_cnt    <= '0;
      b_s1     <= '0;
      b_s1_v   <= 1'b0;
      b_rd     <= '0;
      b_rd_v   <= 1'b0;
      q_a      <= '0;
      q_b      <= '0;
      valid_a  <= 1'b0;
      valid_b  <= 1'b0;
      coll_cnt <= '0;
    end else begin
      req_wr   <= next_req_wr;
      req_rd   <= next_req_rd;
      resp_wr  <= next_resp_wr;
      resp_rd  <= next_resp_rd;
      req_cnt  <= next_req_cnt;
      resp_cnt <= next_resp_cnt;
      a_cnt    <= next_a_cnt;
      b_s1     <= next_b_s1;
      b_s1_v   <= next_b_s1_v;
      b_rd     <= next_b_rd;
      b_rd_v   <= next_b_rd_v;
      q_a      <= next_q_a;
      q_b      <= next_q_b;
      valid_a  <= next_valid_a;
      valid_b  <= next_valid_b;
      coll_cnt <= next_coll_cnt;
    end
  end

  // storage has no reset, no clear and no byte lanes
  always_ff @(posedge pclk) begin
    if (a_push) begin
      req_mem[req_wr] <= '{req: req_a, stamp: a_cnt};
    end
    if (a_srv && a_head.req.re) begin
      resp_mem[resp_wr] <= '{data: mem[a_head.req.addr], stamp: a_head.stamp};
    end
    if (coll) begin
      // safe option runs b then a in one slot, leaving a's word
      mem[b_s1.addr] <= ctrl.safe ? a_head.req.data
                                  : a_head.req.data ^ b_s1.data;
    end else begin
      if (wb) begin
        mem[b_s1.addr] <= b_s1.data;
      end
      if (wa) begin
        mem[a_head.req.addr] <= a_head.req.data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  logic hit;
  assign pready  = 1'b1;
  assign hit     = (paddr == OFS_CTRL) | (paddr == OFS_GEOM) |
                   (paddr == OFS_STAT) | (paddr == OFS_COLL);
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    stat.legal      = legal;
    stat.ratio_emul = ~geom.mem_small & (geom.ratio >= RATIO_EMUL_MIN);
    stat.rdaddr_ext = geom.mem_small;
    stat.active     = active;
    stat.req_full   = req_full;
    stat.resp_full  = resp_full;
  end

  always_comb begin
    next_ctrl   = ctrl;
    next_geom   = geom;
    next_prdata = prdata;
    if (psel && penable && pwrite) begin
      if (paddr == OFS_CTRL) begin
        next_ctrl = cbram_ctrl_t'(pwdata[$bits(cbram_ctrl_t)-1:0]);
      end
      if (paddr == OFS_GEOM) begin
        next_geom = cbram_geom_t'(pwdata[$bits(cbram_geom_t)-1:0]);
      end
    end
    // read data is latched in the setup cycle so the access phase can finish at once
    if (psel && !penable) begin
      next_prdata = '0;
      if (!pwrite) begin
        if (paddr == OFS_CTRL) next_prdata = 32'(ctrl);
        if (paddr == OFS_GEOM) next_prdata = 32'(geom);
        if (paddr == OFS_STAT) next_prdata = 32'(stat);
        if (paddr == OFS_COLL) next_prdata = 32'(coll_cnt);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= CTRL_RST;
      geom   <= GEOM_RST;
      prdata <= '0;
    end else begin
      ctrl   <= next_ctrl;
      geom   <= next_geom;
      prdata <= next_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [LAT_B-1:0] b_hist;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_hist <= '0;
    end else if (b_adv) begin
      b_hist <= {b_hist[LAT_B-2:0], req_b.re};
    end
  end

  a_b_latency: assert property (b_adv |=> valid_b == $past(b_hist[LAT_B-1]))
    else $error("port b read valid not two ticks after request");
  a_safe_keeps_a: assert property (coll && ctrl.safe |=>
      mem[$past(b_s1.addr)] == $past(a_head.req.data))
    else $error("safe dual write did not keep port a data");
  a_dflt_corrupt: assert property (coll && !ctrl.safe && a_head.req.data != b_s1.data |=>
      mem[$past(b_s1.addr)] != $past(a_head.req.data))
    else $error("default dual write left a clean word");
  a_a_min_lat: assert property (a_pop |-> a_age >= STAMP_W'(LAT_A_MIN))
    else $error("port a data delivered too early");
  a_out_hold: assert property (!a_tick |=> $stable(q_a) && $stable(valid_a))
    else $error("port a output moved without a port a edge");
  a_valid_pulse: assert property (a_adv && !a_pop |=> !valid_a)
    else $error("port a valid without data");
  a_freeze_stop: assert property (frozen |=> $stable(b_s1) && $stable(req_cnt))
    else $error("frozen memory accepted work");
  a_fifo_bound: assert property (req_cnt <= CNT_FULL && resp_cnt <= CNT_FULL)
    else $error("fifo count beyond depth");
  a_geom_512: assert property (geom.depth == DEPTH_512 && !geom.mem_small &&
      geom.op != OP_SDP |-> !legal)
    else $error("512 deep accepted outside simple dual port");
  a_ratio_be: assert property (geom.byte_en && geom.ratio > RATIO_MAX_BE |-> !legal)
    else $error("byte enable ratio limit not enforced");
  a_emul_gate: assert property (!(geom.op == OP_TDP && geom.clk_indep) |-> !ready_a)
    else $error("emulation enabled without two clocked rw ports");

  c_collision: cover property (coll);
  c_a_read:    cover property (a_pop ##1 valid_a);
  c_b_read:    cover property (b_adv && b_rd_v);
  c_a_stall:   cover property (active && req_full);

endmodule

/* verification/cbram_user_model.sv */
// partner model: user fabric logic that drives both ram ports
`timescale 1ns/1ps
module cbram_user_model (
  input  logic                  clk_a,
  input  logic                  clk_b,
  input  logic                  ready_a,
  output cbram_pkg::cbram_req_t req_a,
  output logic                  clken_a,
  output cbram_pkg::cbram_req_t req_b,
  output logic                  clken_b
);
  import cbram_pkg::*;

  initial begin
    req_a = '0;
    req_b = '0;
    clken_a = 1'b1;
    clken_b = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // requests change on the falling edge, well past the hold window after the rise
  task automatic op_b(input cbram_req_t r);
    @(negedge clk_b);
    req_b <= r;
  endtask

  task automatic stop_b();
    req_b <= '0;
  endtask

  // port a holds its request until ready_a is seen at a rising edge
  task automatic op_a(input cbram_req_t r, output logic ok);
    int i;
    ok = 1'b0;
    @(negedge clk_a);
    req_a <= r;
    for (i = 0; i < 30 && !ok; i++) begin
      @(posedge clk_a);
      ok = ready_a === 1'b1;
    end
    @(negedge clk_a);
    // released lines show the inverse so stale values cannot pass
    req_a <= '{we: 1'b0, re: 1'b0, addr: ~r.addr, data: ~r.data};
  endtask
endmodule

/* verification/tb_top.sv */
// testbench: registers, both ports, latencies, dual writes, freeze and clock enable
`timescale 1ns/1ps
module tb_top;
  import cbram_pkg::*;
  logic               pclk = 1'b0;
  logic               clk_a = 1'b0;
  logic               clk_b = 1'b0;
  logic               presetn, psel, penable, pwrite, pready, pslverr;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd, c0;
  logic               clken_a, clken_b, ready_a, valid_a, valid_b, er, ok;
  cbram_req_t         req_a, req_b;
  logic [DATA_W-1:0]  q_a, q_b, d, d2;
  logic [ADDR_W-1:0]  a;
  logic [15:0]        lfsr = 16'h003E;
  logic [14:0]        tbl [8];
  int                 n_mismatch = 0;
  int                 cmp_count = 0;

  always #20 pclk = ~pclk;
  // port a slower than port b, both far below pclk/8 for the synchronisers
  always #803 clk_a = ~clk_a;
  always #317 clk_b = ~clk_b;

  cbram_dual_clock #(.FIFO_DEPTH(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_a(clk_a), .clken_a(clken_a), .req_a(req_a), .ready_a(ready_a), .q_a(q_a),
    .valid_a(valid_a), .clk_b(clk_b), .clken_b(clken_b), .req_b(req_b), .q_b(q_b),
    .valid_b(valid_b));
  cbram_user_model u_user (
    .clk_a(clk_a), .clk_b(clk_b), .ready_a(ready_a), .req_a(req_a), .clken_a(clken_a),
    .req_b(req_b), .clken_b(clken_b));

  //////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [DATA_W-1:0] exp_coll(input logic safe, input logic [DATA_W-1:0] da,
                                                 input logic [DATA_W-1:0] db);
    return safe ? da : da ^ db;
  endfunction

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("mismatch at %0t: wait limit, got %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rnd();
    lfsr = lfsr_next(lfsr);
  endtask

  task automatic apb(input logic wr, input logic [PADDR_W-1:0] ad, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) give_up();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read request, one idle tick, then the answer must appear exactly two ticks on
  task automatic b_read(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] ex);
    u_user.op_b('{1'b0, 1'b1, ad, ~ex});
    u_user.op_b('{1'b0, 1'b0, ~ad, ex});
    @(negedge clk_b);
    chk({31'h0, valid_b}, 32'h0);
    @(negedge clk_b);
    chk({11'h0, valid_b, q_b}, {12'h1, ex});
  endtask

  task automatic a_read(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] ex);
    int n;
    u_user.op_a('{1'b0, 1'b1, ad, ~ex}, ok);
    chk({31'h0, ok}, 32'h1);
    for (n = 1; n < 40; n++) begin
      @(negedge clk_a);
      if (valid_a === 1'b1) break;
    end
    if (n == 40) give_up();
    chk({31'h0, n >= LAT_A_MIN}, 32'h1);
    // q_a is only taken once valid_a is high
    chk({11'h0, valid_a, q_a}, {12'h1, ex});
  endtask

  task automatic b_quiet(input logic [ADDR_W-1:0] ad);
    u_user.op_b('{1'b0, 1'b1, ad, '0});
    u_user.op_b('0);
    repeat (3) begin
      @(negedge clk_b);
      chk({31'h0, valid_b}, 32'h0);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #4000000;
    give_up();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tbl = '{{12'h040, 3'h4}, {12'h240, 3'h0}, {12'h540, 3'h4}, {12'h4C0, 3'h0},
            {12'h348, 3'h0}, {12'h168, 3'h6}, {12'h15C, 3'h2}, {12'h848, 3'h1}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_GEOM, 32'h0);
    chk(rd, {20'h0, GEOM_RST});
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    foreach (tbl[k]) begin
      apb(1'b1, OFS_GEOM, {20'h0, tbl[k][14:3]});
      apb(1'b0, OFS_STAT, 32'h0);
      chk({29'h0, rd[5:3]}, {29'h0, tbl[k][2:0]});
    end
    apb(1'b1, OFS_GEOM, {20'h0, GEOM_RST});
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h24);
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      rnd();
      a = lfsr[ADDR_W-1:0];
      d = {lfsr[15:12], lfsr ^ 16'h5A5A};
      if (k == 0) a = '1;
      u_user.op_b('{1'b1, 1'b0, a, d});
      b_read(a, d);
    end
    $display("test port b done");
    a_read(a, d);
    rnd();
    d = {lfsr[3:0], lfsr};
    u_user.op_a('{1'b1, 1'b0, a, d}, ok);
    a_read(a, d);
    b_read(a, d);
    $display("test port a done");
    // port b alternates write and read: a held write would land again after the collision,
    // while the read taken at the colliding tick returns the word two ticks later
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFS_CTRL, {29'h0, 2'h2, s[0]});
      apb(1'b0, OFS_COLL, 32'h0);
      c0 = rd;
      rnd();
      d = {lfsr[3:0], lfsr};
      d2 = {lfsr, lfsr[7:4]};
      fork
        for (int j = 0; j < 20 && rd === c0; j++) begin
          u_user.op_a('{1'b1, 1'b0, a, d}, ok);
          repeat (3) @(negedge clk_b);
        end
        begin
          for (int i = 0; i < 200 && rd === c0; i++) begin
            u_user.op_b('{i[0], ~i[0], a, i[0] ? d2 : ~d2});
            apb(1'b0, OFS_COLL, 32'h0);
          end
          u_user.stop_b();
          repeat (2) @(negedge clk_b);
          chk({11'h0, valid_b, q_b}, {12'h1, exp_coll(s[0], d, d2)});
        end
      join
      if (rd === c0) give_up();
      chk(rd, c0 + 32'h1);
      b_read(a, exp_coll(s[0], d, d2));
    end
    $display("test dual write done");
    repeat (2) @(negedge clk_b);
    apb(1'b1, OFS_CTRL, 32'h6);
    b_quiet(a);
    apb(1'b1, OFS_CTRL, 32'h4);
    u_user.clken_b <= 1'b0;
    b_quiet(a);
    u_user.clken_b <= 1'b1;
    b_read(a, exp_coll(1'b1, d, d2));
    $display("test freeze and enable done");
    test_done();
  end
endmodule
